/* File: multifunction_pin_and_clock_out.sv */
// multifunction pin mux with selectable 13/26 mhz clock output
//
// Summary of operation
// - clock pin gives 15.625 or 31.25 MHz square for 13/26 MHz
// - audio mode toggles only while audio active
// - each of nine pins configured independently
// - disabled pin tristates with pulldown; pin1 default
// - input function returns sampled pin level
// - output function drives software level; pin4 default
// - gnss supply on pins 1-4; pin2 default
// - gnss data ready only on pin3
// - rtc sync output only on pin4
// - sim detect only on pin5, default
// - hot insertion enables sim on card presence
// - network status on pins 1-4, four states
// - audio pins default audio, may be gp
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
module multifunction_pin_and_clock_out #(
  parameter int NPINS = `NUM_MUX_PINS
) (
  input wire logic sys_clk, // 125 mhz clock
  input wire logic rst, // synchronous reset
  input wire logic ce, // clock enable
  input wire logic cfg_we, // configuration write strobe
  input wire logic [3:0] cfg_pin, // pin index 0..8
  input wire pin_mux_pkg::pin_func_e cfg_func, // requested function
  output logic cfg_reject, // last request refused
  input wire logic [NPINS-1:0] gp_out_level, // software output levels
  output logic [NPINS-1:0] gp_in_level, // sampled pin levels
  input wire logic [NPINS-1:0] pin_in, // pad input levels
  output logic [NPINS-1:0] pin_out, // pad output levels
  output logic [NPINS-1:0] pin_oe, // pad drive enables
  output logic [NPINS-1:0] pin_pulldown, // pad pull-down enables
  input wire pin_mux_pkg::net_state_e net_state, // network status
  input wire logic gnss_supply_on, // receiver supply request
  input wire logic rtc_sync, // rtc sync pulse source
  output logic gnss_data_ready, // receiver data-ready sense
  output logic sim_present, // sim card present
  output logic sim_if_enable, // sim interface enable
  input wire logic [3:0] audio_out, // audio codec outputs per pin
  input wire logic [3:0] audio_oe, // audio codec drive enables
  output logic [3:0] audio_in, // audio pin levels to codec
  input wire logic clk_enable, // clock output enable
  input wire logic clk_sel_26, // 1 selects 26 mhz
  input wire logic clk_audio_mode, // 1 gates clock on audio path
  input wire logic audio_active, // audio path active
  output logic clk_out_pin // clock output pin
);
  import pin_mux_pkg::*;

  localparam int HALF13 = `HALF_13M;
  localparam int HALF26 = `HALF_26M;

  typedef struct packed {
    pin_func_e [NPINS-1:0] func;
    logic [NPINS-1:0] sync1;
    logic [NPINS-1:0] sync2;
    logic [NPINS-1:0] gp_in_level;
    logic [NPINS-1:0] pin_out;
    logic [NPINS-1:0] pin_oe;
    logic [NPINS-1:0] pin_pulldown;
    logic cfg_reject;
    logic gnss_data_ready;
    logic sim_present;
    logic sim_if_enable;
    logic [3:0] audio_in;
    logic [7:0] div_cnt;
    logic clk_out_pin;
    logic [1:0] blink;
    logic [7:0] blink_cnt;
  } state_s;

  state_s r;
  state_s next_r;

  // legality of a function on a pin
  function automatic logic func_ok(input logic [3:0] p, input pin_func_e f);
    case (f)
      fn_gp_in, fn_gp_out, fn_disabled: func_ok = 1'b1;
      fn_net_status, fn_gnss_supply: func_ok = (p < 4'h4);
      fn_gnss_drdy: func_ok = (p == 4'(`PIN_GNSS_DRDY));
      fn_rtc_sync: func_ok = (p == 4'(`PIN_RTC_SYNC));
      fn_sim_detect, fn_sim_hot: func_ok = (p == 4'(`PIN_SIM));
      fn_audio: func_ok = (p >= 4'(`PIN_AUDIO_LO)) && (p < 4'(NPINS));
      default: func_ok = 1'b0;
    endcase
  endfunction

  // network status: off, steady on, slow blink, fast blink
  function automatic logic net_level(input net_state_e s, input logic [1:0] b);
    case (s)
      net_no_service: net_level = 1'b0;
      net_home: net_level = 1'b1;
      net_roaming: net_level = b[1];
      net_data: net_level = b[0];
      default: net_level = 1'b0;
    endcase
  endfunction

  always_comb begin
    logic [7:0] half;
    logic run;
    half = clk_sel_26 ? 8'(HALF26) : 8'(HALF13);
    run = 1'b0;
    next_r = r;
    next_r.sync1 = pin_in;
    next_r.sync2 = r.sync1;
    next_r.cfg_reject = 1'b0;
    if (cfg_we) begin
      if ((cfg_pin < 4'(NPINS)) && func_ok(cfg_pin, cfg_func)) begin
        next_r.func[cfg_pin] = cfg_func;
      end else begin
        next_r.cfg_reject = 1'b1;
      end
    end
    next_r.gnss_data_ready = 1'b0;
    next_r.sim_present = 1'b0;
    next_r.sim_if_enable = 1'b1;
    for (int i = 0; i < NPINS; i++) begin
      next_r.gp_in_level[i] = r.sync2[i];
      next_r.pin_out[i] = 1'b0;
      next_r.pin_oe[i] = 1'b0;
      next_r.pin_pulldown[i] = 1'b0;
      case (r.func[i])
        fn_gp_out: begin
          next_r.pin_out[i] = gp_out_level[i];
          next_r.pin_oe[i] = 1'b1;
        end
        fn_disabled: next_r.pin_pulldown[i] = 1'b1;
        fn_net_status: begin
          next_r.pin_out[i] = net_level(net_state, r.blink);
          next_r.pin_oe[i] = 1'b1;
        end
        fn_gnss_supply: begin
          next_r.pin_out[i] = gnss_supply_on;
          next_r.pin_oe[i] = 1'b1;
        end
        fn_gnss_drdy: next_r.gnss_data_ready = r.sync2[i];
        fn_rtc_sync: begin
          next_r.pin_out[i] = rtc_sync;
          next_r.pin_oe[i] = 1'b1;
        end
        fn_sim_detect: next_r.sim_present = r.sync2[i];
        fn_sim_hot: begin
          next_r.sim_present = r.sync2[i];
          next_r.sim_if_enable = r.sync2[i];
        end
        fn_audio: begin
          if (i >= `PIN_AUDIO_LO) begin
            next_r.pin_out[i] = audio_out[i-`PIN_AUDIO_LO];
            next_r.pin_oe[i] = audio_oe[i-`PIN_AUDIO_LO];
          end
        end
        default: ;
      endcase
    end
    for (int k = 0; k < 4; k++) begin
      next_r.audio_in[k] = (r.func[`PIN_AUDIO_LO+k] == fn_audio) ?
                           r.sync2[`PIN_AUDIO_LO+k] : 1'b0;
    end
    // whole-cycle halving of 125 mhz only approximates 13/26 mhz
    run = clk_enable && (!clk_audio_mode || audio_active);
    if (!run) begin
      next_r.div_cnt = 8'h00;
      next_r.clk_out_pin = 1'b0;
    end else if (r.div_cnt + 8'h01 >= half) begin
      next_r.div_cnt = 8'h00;
      next_r.clk_out_pin = !r.clk_out_pin;
    end else begin
      next_r.div_cnt = r.div_cnt + 8'h01;
    end
    // blink runs free so roaming and data stay visible with the clock off;
    // the short period suits simulation, a lamp needs a longer count
    if (r.blink_cnt == 8'(`BLINK_TICKS - 1)) begin
      next_r.blink_cnt = 8'h00;
      next_r.blink = r.blink + 2'h1;
    end else begin
      next_r.blink_cnt = r.blink_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
      for (int i = 0; i < NPINS; i++) begin
        r.func[i] <= fn_gp_in;
      end
      r.func[0] <= fn_disabled;
      r.func[1] <= fn_gnss_supply;
      r.func[2] <= fn_gnss_drdy;
      r.func[3] <= fn_gp_out;
      r.func[4] <= fn_sim_detect;
      for (int i = `PIN_AUDIO_LO; i < NPINS; i++) begin
        r.func[i] <= fn_audio;
      end
      r.pin_pulldown <= '0;
      r.sim_if_enable <= 1'b1;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign cfg_reject = r.cfg_reject;
  assign gp_in_level = r.gp_in_level;
  assign pin_out = r.pin_out;
  assign pin_oe = r.pin_oe;
  assign pin_pulldown = r.pin_pulldown;
  assign gnss_data_ready = r.gnss_data_ready;
  assign sim_present = r.sim_present;
  assign sim_if_enable = r.sim_if_enable;
  assign audio_in = r.audio_in;
  assign clk_out_pin = r.clk_out_pin;

  a_bad_func_kept: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && cfg_we && cfg_pin < 4'(NPINS) && !func_ok(cfg_pin, cfg_func)
    |=> r.cfg_reject && r.func[$past(cfg_pin)] == $past(r.func[cfg_pin]))
    else $error("illegal function changed a pin");
  a_clk_gated_off: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && clk_audio_mode && !audio_active ##1 ce |=> !clk_out_pin)
    else $error("clock toggled with audio inactive");
  a_disabled_pull: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && r.func[0] == fn_disabled |=> pin_pulldown[0] && !pin_oe[0])
    else $error("disabled pin not pulled down");
  a_gp_out_drive: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && r.func[3] == fn_gp_out
    |=> pin_oe[3] && pin_out[3] == $past(gp_out_level[3]))
    else $error("output pin level wrong");
  a_gp_in_sample: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce ##1 ce ##1 ce |=> gp_in_level == $past(pin_in, 3))
    else $error("input level not sampled");
  a_clk_runs: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ce && clk_enable && !clk_audio_mode && clk_sel_26) [*8]
    |-> clk_out_pin != $past(clk_out_pin, 2))
    else $error("26 mhz clock not toggling");
  a_hot_sim: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && r.func[4] == fn_sim_hot |=> sim_if_enable == $past(r.sync2[4]))
    else $error("sim enable does not follow card");
  a_drdy_sense: assert property (
    @(posedge sys_clk) disable iff (rst)
    ce && r.func[2] == fn_gnss_drdy |=> gnss_data_ready == $past(r.sync2[2]))
    else $error("data ready not sensed");
endmodule

/* File: multifunction_pin_and_clock_out_tb.sv */
// self-checking bench for the pin mux and clock output
`timescale 1ns/1ps
`include "pin_mux_defs.svh"
module multifunction_pin_and_clock_out_tb;
  import pin_mux_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, cfg_we = 1'b0, cfg_reject, ce = 1'b1;
  logic [3:0] cfg_pin = 4'h0, audio_out = 4'h0, audio_oe = 4'h0, audio_in;
  pin_func_e cfg_func = fn_gp_in;
  net_state_e net_state = net_no_service;
  logic [8:0] gp_out_level = 9'h008, gp_in_level, pin_in, pin_out, pin_oe;
  logic [8:0] pin_pulldown, ext_en = 9'h014, ext_val = 9'h014;
  logic gnss_supply_on = 1'b1, rtc_sync = 1'b0, gnss_data_ready;
  logic sim_present, sim_if_enable, clk_out_pin, clk_enable = 1'b0;
  logic clk_sel_26 = 1'b1, clk_audio_mode = 1'b0, audio_active = 1'b0;
  int err_count = 0, total_checks = 0;
  always #4 sys_clk = ~sys_clk;
  multifunction_pin_and_clock_out dut_u (.sys_clk(sys_clk), .rst(rst),
    .ce(ce), .cfg_we(cfg_we), .cfg_pin(cfg_pin), .cfg_func(cfg_func),
    .cfg_reject(cfg_reject), .gp_out_level(gp_out_level),
    .gp_in_level(gp_in_level), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pulldown(pin_pulldown), .net_state(net_state),
    .gnss_supply_on(gnss_supply_on), .rtc_sync(rtc_sync),
    .gnss_data_ready(gnss_data_ready), .sim_present(sim_present),
    .sim_if_enable(sim_if_enable), .audio_out(audio_out),
    .audio_oe(audio_oe), .audio_in(audio_in), .clk_enable(clk_enable),
    .clk_sel_26(clk_sel_26), .clk_audio_mode(clk_audio_mode),
    .audio_active(audio_active), .clk_out_pin(clk_out_pin));
  pin_partner far_u (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pulldown(pin_pulldown), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [8:0] exp, logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // reject is a one-cycle pulse right after the request edge
  task automatic cfg(logic [3:0] p, pin_func_e f, logic exp_rej);
    cfg_pin = p;
    cfg_func = f;
    cfg_we = 1'b1;
    cyc(1);
    cfg_we = 1'b0;
    chk("reject", exp_rej, cfg_reject);
    cyc(1);
    chk("reject_end", 1'b0, cfg_reject);
    cyc(2);
  endtask
  task automatic t_defaults();
    audio_oe = 4'h1;
    audio_out = 4'h1;
    ext_en[8:6] = 3'h7;
    ext_val[8:6] = 3'h5;
    cyc(4);
    chk("pd0", 9'h001, pin_pulldown & 9'h001);
    chk("oe", 9'h02a, pin_oe & 9'h02b);
    chk("out", 9'h02a, pin_out & 9'h02a);
    chk("drdy_sim", 2'h3, {gnss_data_ready, sim_present});
    chk("aud_in", 4'ha, audio_in & 4'he);
    chk("clk_off", 1'b0, clk_out_pin);
    cfg(4'h5, fn_gp_out, 1'b0);
    chk("aud_gp", 1'b0, pin_out[5]);
    cfg(4'h6, fn_net_status, 1'b1);
    cfg(4'h5, fn_sim_detect, 1'b1);
  endtask
  task automatic t_pins();
    int nr, nd;
    ext_en[0] = 1'b1;
    ext_val[0] = 1'b1;
    cfg(4'h0, fn_gp_in, 1'b0);
    cyc(1);
    chk("gp_in", 1'b1, gp_in_level[0]);
    ext_val[0] = 1'b0;
    cyc(4);
    chk("gp_in", 1'b0, gp_in_level[0]);
    gp_out_level[0] = 1'b1;
    cfg(4'h0, fn_gp_out, 1'b0);
    chk("gp_out", 9'h009, pin_out & pin_oe & 9'h009);
    cfg(4'h0, fn_rtc_sync, 1'b1);
    cfg(4'h0, fn_gnss_drdy, 1'b1);
    cfg(4'h9, fn_gp_in, 1'b1);
    chk("kept", 1'b1, pin_out[0] & pin_oe[0]);
    cfg(4'h3, fn_rtc_sync, 1'b0);
    rtc_sync = 1'b1;
    cyc(2);
    chk("rtc", 1'b1, pin_out[3]);
    gnss_supply_on = 1'b0;
    cfg(4'h0, fn_gnss_supply, 1'b0);
    chk("supply", 1'b0, pin_out[0]);
    net_state = net_home;
    cfg(4'h0, fn_net_status, 1'b0);
    chk("net_home", 1'b1, pin_out[0] & pin_oe[0]);
    net_state = net_no_service;
    cyc(3);
    chk("net_none", 1'b0, pin_out[0]);
    blink_count(net_roaming, nr);
    blink_count(net_data, nd);
    chk("net_blink", 1'b1, nr > 0 && nd > nr);
  endtask
  // counts level changes on pin 0 with the clock output still off
  task automatic blink_count(net_state_e s, output int n);
    logic v;
    n = 0;
    net_state = s;
    cyc(2);
    v = pin_out[0];
    repeat (96) begin
      cyc(1);
      if (pin_out[0] !== v) n++;
      v = pin_out[0];
    end
  endtask
  task automatic t_sim();
    ext_val[4] = 1'b0;
    ext_val[2] = 1'b0;
    cfg(4'h4, fn_sim_hot, 1'b0);
    cyc(3);
    chk("sim_off", 1'b0, sim_if_enable);
    chk("drdy_off", 1'b0, gnss_data_ready);
    ext_val[4] = 1'b1;
    cyc(5);
    chk("sim_on", 1'b1, sim_if_enable);
    ext_val[4] = 1'b0;
    cyc(4);
    chk("sim_gone", 1'b0, sim_if_enable);
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    cyc(4);
    chk("rst_sim", 1'b1, sim_if_enable);
    chk("rst_pd", 9'h001, {pin_oe[0], pin_pulldown[0]});
  endtask
  task automatic half(int exp);
    int n;
    n = 0;
    for (int i = 0; i < 40 && clk_out_pin !== 1'b0; i++) cyc(1);
    for (int i = 0; i < 40 && clk_out_pin !== 1'b1; i++) cyc(1);
    while (clk_out_pin === 1'b1 && n < 40) begin
      n++;
      cyc(1);
    end
    if (n == 0 || n == 40) begin
      chk("clk_wait", 9'h001, 9'h000);
      final_report();
    end else begin
      chk("clk_half", exp[8:0], n[8:0]);
    end
  endtask
  task automatic t_clk();
    int n;
    logic v;
    n = 0;
    clk_enable = 1'b1;
    half(`HALF_26M);
    clk_sel_26 = 1'b0;
    half(`HALF_13M);
    clk_audio_mode = 1'b1;
    cyc(3);
    repeat (20) begin
      cyc(1);
      if (clk_out_pin !== 1'b0) n++;
    end
    chk("gated", 9'h000, n[8:0]);
    audio_active = 1'b1;
    half(`HALF_13M);
    ce = 1'b0;
    n = 0;
    v = clk_out_pin;
    repeat (12) begin
      cyc(1);
      if (clk_out_pin !== v) n++;
    end
    chk("ce_hold", 9'h000, n[8:0]);
    ce = 1'b1;
    half(`HALF_13M);
  endtask
  initial begin
    cyc(3);
    rst = 1'b0;
    t_defaults();
    t_pins();
    t_sim();
    t_clk();
    final_report();
  end
endmodule

/* File: pin_mux_defs.svh */
// constants for the multifunction pin mux and clock output
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH
`define NUM_MUX_PINS 9
`define FUNC_W 4
`define PIN_GNSS_DRDY 2
`define PIN_RTC_SYNC 3
`define PIN_SIM 4
`define PIN_AUDIO_LO 5
`define SYS_CLK_HZ 125000000
`define CLK_13M_HZ 13000000
`define CLK_26M_HZ 26000000
`define HALF_13M ((`SYS_CLK_HZ / `CLK_13M_HZ) / 2)
`define HALF_26M ((`SYS_CLK_HZ / `CLK_26M_HZ) / 2)
`define STATUS_W 2
`define BLINK_TICKS 16
`endif

/* File: pin_mux_pkg.sv */
// types for the multifunction pin mux
package pin_mux_pkg;
  typedef enum logic [3:0] {
    fn_gp_in, fn_gp_out, fn_disabled, fn_net_status, fn_gnss_supply,
    fn_gnss_drdy, fn_rtc_sync, fn_sim_detect, fn_sim_hot, fn_audio
  } pin_func_e;
  typedef enum logic [1:0] {
    net_no_service, net_home, net_roaming, net_data
  } net_state_e;
endpackage

/* File: pin_partner.sv */
// far side of the pads: receiver, sim holder and codec levels
`timescale 1ns/1ps
module pin_partner (
  input wire logic sys_clk, // system clock
  input wire logic [8:0] pin_out, // device level
  input wire logic [8:0] pin_oe, // device drives
  input wire logic [8:0] pin_pulldown, // device pull-down
  input wire logic [8:0] ext_en, // far side drives
  input wire logic [8:0] ext_val, // far side level
  output logic [8:0] pin_in // pad level
);
  logic alt = 1'b0;
  // a floating pad wanders so a stale level never passes
  always @(posedge sys_clk) alt <= ~alt;
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
        pin_pulldown[i] ? 1'b0 : alt;
    end
  end
endmodule
